// ### rtl/sram_ctrl_pkg.sv
// Constants, pin bundle and request types for the static memory controller
package sram_ctrl_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int SYNC_STAGES = 2;

  // Clock and memory timing, in nanoseconds
  localparam int CLK_PERIOD_NS = 50;
  localparam int ACCESS_NS = 35;
  localparam int WRITE_PULSE_NS = 20;
  localparam int WRITE_LOW_TO_FLOAT_DELAY_NS = 7;
  localparam int WRITE_DATA_SETUP_TIME_NS = 12;

  // Least times round up, never below one cycle
  localparam int ACCESS_RAW = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_RAW < 1) ? 1 : ACCESS_RAW;
  localparam int FLOAT_RAW = (WRITE_LOW_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (FLOAT_RAW < 1) ? 1 : FLOAT_RAW;
  localparam int PULSE_NS = (WRITE_PULSE_NS > WRITE_DATA_SETUP_TIME_NS) ? WRITE_PULSE_NS : WRITE_DATA_SETUP_TIME_NS;
  localparam int PULSE_RAW = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
  localparam int READ_WAIT_CYC = ACCESS_CYC + SYNC_STAGES;

  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] READ_LOAD = CNT_W'(READ_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] FLOAT_LOAD = CNT_W'(FLOAT_CYC - 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);

  localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_WR_SETUP,
    ST_WR_FLOAT,
    ST_WR_PULSE,
    ST_WR_HOLD
  } ctrl_state_e;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sram_req_s;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
  } sram_pins_s;

  localparam sram_pins_s PINS_RESET = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: ADDR_RESET,
                                        dq_out: DATA_RESET, dq_oe_n: 1'b1};

endpackage

// ### rtl/sram_dq_sync.sv
// Two-flop synchroniser for the memory data pins
`timescale 1ns/1ps
module sram_dq_sync
  import sram_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin side and synchronised side
  input wire logic [DATA_W-1:0] i_pin,
  output logic [DATA_W-1:0] o_sync
);

  logic [DATA_W-1:0] meta_reg;
  logic [DATA_W-1:0] sync_reg;

  genvar b;
  generate
    for (b = 0; b < DATA_W; b++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_reg[b] <= 1'b0;
          sync_reg[b] <= 1'b0;
        end else begin
          meta_reg[b] <= i_pin[b];
          sync_reg[b] <= meta_reg[b];
        end
      end
    end
  endgenerate

  assign o_sync = sync_reg;

endmodule

// ### rtl/sram_ctrl.sv
// Host-side controller driving an asynchronous 32K x 8 static memory
`timescale 1ns/1ps
// What this block does
// - A write happens only while select and write strobes are both low; in select-controlled writes the host lowers both together.
// - Write data is set up and held around the rising edge of the strobe that ends the write.
// - A write with output drive low and write strobe in control lasts at least float delay plus data setup.
// - The host does not drive data while the memory drives its pins during a write cycle.
// - In address-controlled reads select and output drive stay low and only the address changes.
// - The write strobe stays high through every read cycle.
// - In a select-controlled read the address is valid no later than select falling.
module sram_ctrl
  import sram_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // User request
  input wire logic I_REQ_VALID,
  input wire sram_req_s I_REQ,
  input wire logic I_ADDR_MODE,
  output logic O_REQ_READY,
  // Read answer
  output logic O_RD_VALID,
  output logic [DATA_W-1:0] O_RD_DATA,
  // Memory pins
  output sram_pins_s O_SRAM,
  input wire logic [DATA_W-1:0] I_SRAM_DQ
);

  ctrl_state_e state_reg;
  ctrl_state_e state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  sram_req_s req_reg;
  logic mode_reg;
  sram_pins_s pins_reg;
  sram_pins_s pins_next;
  logic ready_reg;
  logic rd_valid_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] dq_sync;
  logic take;
  logic cnt_done;
  logic rd_done;

  assign take = I_REQ_VALID && ready_reg && (state_reg == ST_IDLE);
  assign cnt_done = (cnt_reg == CNT_ZERO);
  assign rd_done = (state_reg == ST_RD_WAIT) && cnt_done;

  // Pins cross in through two flops
  sram_dq_sync u_dq_sync (
    .clk(I_CLK),
    .rst(I_RST),
    .i_pin(I_SRAM_DQ),
    .o_sync(dq_sync)
  );

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = I_REQ.write ? ST_WR_SETUP : ST_RD_SETUP;
        end
      end
      ST_RD_SETUP: state_next = ST_RD_WAIT;
      ST_RD_WAIT: begin
        if (cnt_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_WR_SETUP: state_next = mode_reg ? ST_WR_FLOAT : ST_WR_PULSE;
      ST_WR_FLOAT: begin
        if (cnt_done) begin
          state_next = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE: begin
        if (cnt_done) begin
          state_next = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Dwell counter, loaded on each state entry
  // Zero means the dwell is over; it never wraps
  always_comb begin
    cnt_next = cnt_done ? CNT_ZERO : cnt_reg - CNT_ONE;
    if (state_next != state_reg) begin
      case (state_next)
        ST_RD_WAIT: cnt_next = READ_LOAD;
        ST_WR_FLOAT: cnt_next = FLOAT_LOAD;
        ST_WR_PULSE: cnt_next = PULSE_LOAD;
        default: cnt_next = CNT_ZERO;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cnt_reg <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Request capture
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      req_reg <= '0;
    end else if (take) begin
      req_reg <= I_REQ;
    end
  end

  // Mode follows the input while idle, frozen during an access
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mode_reg <= 1'b0;
    end else if (state_next == ST_IDLE) begin
      mode_reg <= I_ADDR_MODE;
    end
  end

  // Pin values for the coming state
  always_comb begin
    pins_next = pins_reg;
    pins_next.we_n = 1'b1;
    pins_next.dq_oe_n = 1'b1;
    case (state_next)
      ST_IDLE: begin
        pins_next.ce_n = ~I_ADDR_MODE;
        pins_next.oe_n = ~I_ADDR_MODE;
      end
      ST_RD_SETUP: begin
        pins_next.addr = take ? I_REQ.addr : req_reg.addr;
        pins_next.ce_n = ~mode_reg;
        pins_next.oe_n = ~mode_reg;
      end
      ST_RD_WAIT: begin
        pins_next.ce_n = 1'b0;
        pins_next.oe_n = 1'b0;
      end
      ST_WR_SETUP: begin
        pins_next.addr = take ? I_REQ.addr : req_reg.addr;
        pins_next.dq_out = take ? I_REQ.wdata : req_reg.wdata;
        pins_next.ce_n = ~mode_reg;
        pins_next.oe_n = ~mode_reg;
      end
      ST_WR_FLOAT: begin
        pins_next.ce_n = 1'b0;
        pins_next.we_n = 1'b0;
        pins_next.oe_n = 1'b0;
        pins_next.dq_oe_n = 1'b1;
      end
      ST_WR_PULSE: begin
        pins_next.ce_n = 1'b0;
        pins_next.we_n = 1'b0;
        pins_next.oe_n = ~mode_reg;
        pins_next.dq_oe_n = 1'b0;
      end
      ST_WR_HOLD: begin
        // Write strobe alone ends the write; data held past its rise
        pins_next.ce_n = 1'b0;
        pins_next.we_n = 1'b1;
        pins_next.oe_n = 1'b1;
        pins_next.dq_oe_n = 1'b0;
      end
      default: pins_next = PINS_RESET;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      pins_reg <= PINS_RESET;
    end else begin
      pins_reg <= pins_next;
    end
  end

  // Ready while the next state is idle
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == ST_IDLE);
    end
  end

  // Read answer, byte taken from the synchronised pins
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= DATA_RESET;
    end else begin
      rd_valid_reg <= rd_done;
      if (rd_done) begin
        rd_data_reg <= dq_sync;
      end
    end
  end

  assign O_REQ_READY = ready_reg;
  assign O_RD_VALID = rd_valid_reg;
  assign O_RD_DATA = rd_data_reg;
  assign O_SRAM = pins_reg;

endmodule

// ### verif/sram_ctrl_assertions.sv
// Pin protocol checks for the static memory controller
`timescale 1ns/1ps
module sram_ctrl_assertions
  import sram_ctrl_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_REQ_VALID,
  input wire sram_req_s I_REQ,
  input wire logic I_ADDR_MODE,
  input wire logic O_REQ_READY,
  input wire logic O_RD_VALID,
  input wire sram_pins_s O_SRAM
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  sequence s_rd_take;
    I_REQ_VALID && O_REQ_READY && !I_REQ.write;
  endsequence
  sequence s_wr_take;
    I_REQ_VALID && O_REQ_READY && I_REQ.write;
  endsequence
  property p_rd_we_high;
    s_rd_take |=> O_SRAM.we_n [*5];
  endproperty
  a_rd_we_high: assert property (p_rd_we_high) else $error("write strobe low in read");
  property p_rd_answer;
    s_rd_take |-> ##5 O_RD_VALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_addr_mode;
    s_rd_take ##0 $past(I_ADDR_MODE) |=> (!O_SRAM.ce_n && !O_SRAM.oe_n) [*5];
  endproperty
  a_addr_mode: assert property (p_addr_mode) else $error("strobes left low mode");
  property p_wr_start;
    s_wr_take |-> ##2 (!O_SRAM.ce_n && !O_SRAM.we_n);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write window missing");
  property p_wr_hold;
    $rose(O_SRAM.we_n) |-> !O_SRAM.dq_oe_n && $stable(O_SRAM.dq_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("data not held at write end");
  property p_wr_pulse;
    $fell(O_SRAM.we_n) && !O_SRAM.oe_n |-> !O_SRAM.we_n [*2];
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write too short");
  property p_no_fight;
    !O_SRAM.dq_oe_n |-> (O_SRAM.ce_n || !O_SRAM.we_n || O_SRAM.oe_n);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("data pin contention");
  property p_addr_first;
    $fell(O_SRAM.ce_n) |-> $stable(O_SRAM.addr);
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("address late");
endmodule
bind sram_ctrl sram_ctrl_assertions sram_ctrl_assertions_i (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ), .I_ADDR_MODE(I_ADDR_MODE), .O_REQ_READY(O_REQ_READY),
  .O_RD_VALID(O_RD_VALID), .O_SRAM(O_SRAM));

// ### verif/sram_model.sv
// Behavioural static memory on the controller pins
`timescale 1ns/1ps
module sram_model
  import sram_ctrl_pkg::*;
(
  input wire sram_pins_s i_pins,
  output logic [DATA_W-1:0] o_dq
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last;
  logic drive;
  assign drive = !i_pins.ce_n && i_pins.we_n && !i_pins.oe_n;
  // Released pins show the inverse of the last byte
  assign o_dq = drive ? mem[i_pins.addr] : ~last;
  always @(posedge (i_pins.ce_n | i_pins.we_n)) begin
    if (i_pins.dq_oe_n === 1'b0)
      mem[i_pins.addr] <= i_pins.dq_out;
  end
  always @* begin
    if (drive)
      last = mem[i_pins.addr];
  end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
module testbench;
  import sram_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  sram_req_s req = '0;
  logic addr_mode = 1'b0;
  logic req_ready;
  logic rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] mem_dq;
  logic [DATA_W-1:0] dq;
  sram_pins_s pins;
  int mismatches = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  assign dq = pins.dq_oe_n ? mem_dq : pins.dq_out;
  sram_ctrl sram_ctrl_i (.I_CLK(clk), .I_RST(rst), .I_REQ_VALID(req_valid), .I_REQ(req),
    .I_ADDR_MODE(addr_mode), .O_REQ_READY(req_ready), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data),
    .O_SRAM(pins), .I_SRAM_DQ(dq));
  sram_model sram_model_i (.i_pins(pins), .o_dq(mem_dq));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      check(1'b0, "ready timeout");
      tally_and_finish();
    end
    req = '{write: wr, addr: a, wdata: d};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    check(req_ready === 1'b0, "ready after take");
    n = 0;
    while (!wr && rd_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      check(1'b0, "read timeout");
      tally_and_finish();
    end
    if (!wr) begin
      check(n == READ_WAIT_CYC + 1, "read latency");
    end
    q = rd_data;
  endtask
  task automatic t_idle;
    check(pins.ce_n === 1'b1 && pins.we_n === 1'b1 && pins.oe_n === 1'b1 && pins.dq_oe_n === 1'b1, "idle pins");
    $display("t_idle done");
  endtask
  task automatic t_rw(input logic mode);
    logic [DATA_W-1:0] q;
    logic [DATA_W-1:0] d;
    addr_mode = mode;
    d = mode ? 8'h3C : 8'hA5;
    // Mode settles at an idle edge before the first access
    @(negedge clk);
    check(pins.ce_n === ~mode && pins.oe_n === ~mode, "idle strobes follow mode");
    access(1'b1, 15'h0000, ~d, q);
    access(1'b1, 15'h7FFF, d, q);
    access(1'b1, 15'h0000, d ^ 8'h0F, q);
    access(1'b0, 15'h0000, 8'h00, q);
    check(q === (d ^ 8'h0F), "low end byte");
    access(1'b0, 15'h7FFF, 8'h00, q);
    check(q === d, "high end byte");
    $display("t_rw mode %0d done", mode);
  endtask
  task automatic t_reset;
    logic [DATA_W-1:0] q;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check(req_ready === 1'b0 && rd_valid === 1'b0 && pins.ce_n === 1'b1 && pins.oe_n === 1'b1, "pins in reset");
    rst = 1'b0;
    @(negedge clk);
    check(req_ready === 1'b1 && pins.ce_n === ~addr_mode, "ready after reset");
    access(1'b0, 15'h7FFF, 8'h00, q);
    check(q === 8'h3C, "byte kept over reset");
    $display("t_reset done");
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_idle();
    t_rw(1'b0);
    t_rw(1'b1);
    t_reset();
    tally_and_finish();
  end
endmodule
